// [hw/fci_pkg.sv]
/*
 * shared constants of the flash command interface controller: register map,
 * operation codes, flash command bytes, status bits and pin timing.
 * assumes a 40 MHz clock and an 8-bit parallel flash with a 20-bit address.
 */
package fci_pkg;

	// register byte offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_WDATA  = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_CFG    = 8'h10;

	// cfg field positions and reset value
	localparam int          CFG_RP_N   = 0;
	localparam int          CFG_RP_HV  = 1;
	localparam int          CFG_VPP_EN = 2;
	localparam logic [2:0]  CFG_RESET  = 3'h5;

	// status register field positions
	localparam int STS_BUSY    = 0;
	localparam int STS_REFUSED = 1;
	localparam int STS_RDY_PIN = 2;
	localparam int STS_SUSP    = 3;
	localparam int STS_SR_LSB  = 8;
	localparam int STS_RD_LSB  = 16;

	// operations software may start through ctrl[3:0]
	localparam logic [3:0] OP_READ     = 4'h0;
	localparam logic [3:0] OP_RD_ARRAY = 4'h1;
	localparam logic [3:0] OP_RD_ID    = 4'h2;
	localparam logic [3:0] OP_RD_STAT  = 4'h3;
	localparam logic [3:0] OP_CLR_STAT = 4'h4;
	localparam logic [3:0] OP_ERASE    = 4'h5;
	localparam logic [3:0] OP_BYTE_WR  = 4'h6;
	localparam logic [3:0] OP_SUSPEND  = 4'h7;
	localparam logic [3:0] OP_RESUME   = 4'h8;
	localparam logic [3:0] OP_RAW_WR   = 4'h9;

	// flash command bytes
	localparam logic [7:0] CMD_RD_ARRAY = 8'hff;
	localparam logic [7:0] CMD_RD_ID    = 8'h90;
	localparam logic [7:0] CMD_RD_STAT  = 8'h70;
	localparam logic [7:0] CMD_CLR_STAT = 8'h50;
	localparam logic [7:0] CMD_ERASE    = 8'h20;
	localparam logic [7:0] CMD_CONFIRM  = 8'hd0;
	localparam logic [7:0] CMD_BYTE_WR  = 8'h40;
	localparam logic [7:0] CMD_SUSPEND  = 8'hb0;

	// flash status byte bits
	localparam int SR_READY = 7;
	localparam int SR_ESUSP = 6;

	// pin timing
	localparam int CLK_MHZ   = 40;
	localparam int T_ACC_NS  = 120;
	localparam int T_WP_NS   = 50;
	localparam int T_REC_NS  = 30;
	localparam int SYNC_LAT  = 2;
	localparam int ACC_CYC   = (T_ACC_NS * CLK_MHZ + 999) / 1000 + SYNC_LAT;
	localparam int WP_CYC    = (T_WP_NS * CLK_MHZ + 999) / 1000;
	localparam int REC_CYC   = (T_REC_NS * CLK_MHZ + 999) / 1000;

endpackage

// [hw/fci_cyc_if.sv]
/*
 * request and answer of one flash bus cycle between the sequencer and the
 * pin driver. assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface fci_cyc_if;
	logic        req;   // one-cycle pulse
	logic        wr;
	logic [19:0] addr;
	logic [7:0]  wdata;
	logic        done;  // one-cycle pulse
	logic [7:0]  rdata;

	modport master (output req, output wr, output addr, output wdata,
		input done, input rdata);
	modport slave (input req, input wr, input addr, input wdata,
		output done, output rdata);
endinterface

// [hw/fci_pins.sv]
/*
 * drives one read or write cycle on the flash pins: select, strobe, hold
 * and recovery. assumes requests arrive only after the previous done.
 */
`timescale 1ns/1ps
module fci_pins (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	fci_cyc_if.slave        cyc,
	input  wire logic [7:0] dq_i,
	output logic [19:0]     addr_o,
	output logic [7:0]      dq_o,
	output logic            dq_oe_o,
	output logic            ce_n_o,
	output logic            oe_n_o,
	output logic            we_n_o
);
	typedef enum logic [3:0] {
		C_IDLE   = 4'h1,
		C_SETUP  = 4'h2,
		C_STROBE = 4'h4,
		C_REC    = 4'h8
	} fci_cstate_e;

	fci_cstate_e state;
	logic [3:0]  cnt;
	logic        wr;
	logic [7:0]  dq_meta;
	logic [7:0]  dq_sync;

	// data pins come from outside the clock domain
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dq_meta <= 8'h00;
			dq_sync <= 8'h00;
		end else begin
			dq_meta <= dq_i;
			dq_sync <= dq_meta;
		end
	end

	// cycle sequencer with its pin flip-flops
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state     <= C_IDLE;
			cnt       <= 4'h0;
			wr        <= 1'b0;
			addr_o    <= 20'h00000;
			dq_o      <= 8'h00;
			dq_oe_o   <= 1'b0;
			ce_n_o    <= 1'b1;
			oe_n_o    <= 1'b1;
			we_n_o    <= 1'b1;
			cyc.done  <= 1'b0;
			cyc.rdata <= 8'h00;
		end else begin
			cyc.done <= 1'b0;
			unique case (state)
			C_IDLE: if (cyc.req) begin
				wr      <= cyc.wr;
				addr_o  <= cyc.addr;
				dq_o    <= cyc.wdata;
				dq_oe_o <= cyc.wr;
				ce_n_o  <= 1'b0;
				state   <= C_SETUP;
			end
			C_SETUP: begin
				we_n_o <= ~wr;
				oe_n_o <= wr;
				cnt    <= wr ? 4'(fci_pkg::WP_CYC) : 4'(fci_pkg::ACC_CYC);
				state  <= C_STROBE;
			end
			C_STROBE: if (cnt == 4'h1) begin
				if (!wr)
					cyc.rdata <= dq_sync;
				// strobe rises before select so the write latches on it
				we_n_o <= 1'b1;
				oe_n_o <= 1'b1;
				cnt    <= 4'(fci_pkg::REC_CYC);
				state  <= C_REC;
			end else begin
				cnt <= cnt - 4'h1;
			end
			C_REC: begin
				ce_n_o  <= 1'b1;
				dq_oe_o <= 1'b0;
				if (cnt == 4'h1) begin
					cyc.done <= 1'b1;
					state    <= C_IDLE;
				end else begin
					cnt <= cnt - 4'h1;
				end
			end
			endcase
		end
	end
endmodule

// [hw/fci_top.sv]
/*
 * flash command interface controller: a classic wishbone slave whose
 * registers start command sequences on an external 8-bit parallel flash
 * and report the flash status. assumes a 40 MHz clock and asynchronous
 * flash pins; data and ready pins are synchronised here.
 */
`timescale 1ns/1ps
module fci_top (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	output logic [19:0]      fl_addr_o,
	input  wire logic [7:0]  fl_dq_i,
	output logic [7:0]       fl_dq_o,
	output logic             fl_dq_oe_o,
	output logic             fl_ce_n_o,
	output logic             fl_oe_n_o,
	output logic             fl_we_n_o,
	output logic             fl_rp_n_o,
	output logic             fl_rp_hv_o,
	output logic             fl_vpp_en_o,
	input  wire logic        fl_ready_busy_n_i
);
	typedef enum logic [5:0] {
		S_IDLE = 6'h01,
		S_CMD  = 6'h02,
		S_DATA = 6'h04,
		S_READ = 6'h08,
		S_POLL = 6'h10,
		S_DONE = 6'h20
	} fci_state_e;

	logic        rst_meta;
	logic        rst_n;
	logic        rdy_meta;
	logic        rdy_sync;
	fci_state_e  state;
	logic        pend;
	logic [3:0]  op;
	logic [19:0] addr;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic [7:0]  sr;
	logic        refused;
	logic        start;
	logic        reject;
	logic [7:0]  cmd1;
	logic        two_wr;
	logic        do_read;
	logic        do_poll;
	logic        wb_req;

	fci_cyc_if cyc ();

	// reset release through two flip-flops
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ready pin synchroniser
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rdy_meta <= 1'b1;
			rdy_sync <= 1'b1;
		end else begin
			rdy_meta <= fl_ready_busy_n_i;
			rdy_sync <= rdy_meta;
		end
	end

	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign start  = wb_req & wb_we_i & wb_sel_i[0]
		& (wb_adr_i == fci_pkg::REG_CTRL) & (state == S_IDLE);

	// plan of the sequence for the latched operation in op
	always_comb begin
		cmd1    = fci_pkg::CMD_RD_ARRAY;
		two_wr  = 1'b0;
		do_read = 1'b0;
		do_poll = 1'b0;
		case (op)
		fci_pkg::OP_READ:     do_read = 1'b1;
		fci_pkg::OP_RD_ARRAY: do_read = 1'b1;
		fci_pkg::OP_RD_ID: begin
			cmd1    = fci_pkg::CMD_RD_ID;
			do_read = 1'b1;
		end
		fci_pkg::OP_RD_STAT: begin
			cmd1    = fci_pkg::CMD_RD_STAT;
			do_read = 1'b1;
		end
		fci_pkg::OP_CLR_STAT: cmd1 = fci_pkg::CMD_CLR_STAT;
		fci_pkg::OP_ERASE: begin
			cmd1    = fci_pkg::CMD_ERASE;
			two_wr  = 1'b1;
			do_poll = 1'b1;
		end
		fci_pkg::OP_BYTE_WR: begin
			cmd1    = fci_pkg::CMD_BYTE_WR;
			two_wr  = 1'b1;
			do_poll = 1'b1;
		end
		fci_pkg::OP_SUSPEND: begin
			cmd1    = fci_pkg::CMD_SUSPEND;
			do_poll = 1'b1;
		end
		fci_pkg::OP_RESUME:   cmd1 = fci_pkg::CMD_CONFIRM;
		default:              cmd1 = wdata;
		endcase
	end

	// operations that the device would ignore or that break its order
	always_comb begin
		reject = 1'b0;
		case (wb_dat_i[3:0])
		fci_pkg::OP_RD_ARRAY: reject = ~rdy_sync;
		fci_pkg::OP_CLR_STAT: reject = sr[fci_pkg::SR_ESUSP];
		fci_pkg::OP_ERASE:    reject = sr[fci_pkg::SR_ESUSP];
		fci_pkg::OP_RESUME:   reject = ~rdy_sync;
		fci_pkg::OP_SUSPEND:  reject = rdy_sync;
		default:              reject = 1'b0;
		endcase
	end

	// command sequencer
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state     <= S_IDLE;
			pend      <= 1'b0;
			op        <= fci_pkg::OP_READ;
			refused   <= 1'b0;
			rdata     <= 8'h00;
			sr        <= 8'h80;
			cyc.req   <= 1'b0;
			cyc.wr    <= 1'b0;
			cyc.addr  <= 20'h00000;
			cyc.wdata <= 8'h00;
		end else begin
			cyc.req <= 1'b0;
			unique case (state)
			S_IDLE: if (start) begin
				refused <= reject;
				op      <= wb_dat_i[3:0];
				state   <= reject ? S_IDLE : S_CMD;
			end
			S_CMD: if (!pend) begin
				pend      <= 1'b1;
				cyc.req   <= (op != fci_pkg::OP_READ);
				cyc.wr    <= 1'b1;
				cyc.addr  <= addr;
				cyc.wdata <= cmd1;
				if (op == fci_pkg::OP_READ) begin
					pend  <= 1'b0;
					state <= S_READ;
				end
			end else if (cyc.done) begin
				pend  <= 1'b0;
				state <= two_wr ? S_DATA : do_read ? S_READ
					: do_poll ? S_POLL : S_DONE;
			end
			S_DATA: if (!pend) begin
				pend      <= 1'b1;
				cyc.req   <= 1'b1;
				cyc.wr    <= 1'b1;
				cyc.addr  <= addr;
				cyc.wdata <= (op == fci_pkg::OP_ERASE)
					? fci_pkg::CMD_CONFIRM : wdata;
			end else if (cyc.done) begin
				pend  <= 1'b0;
				state <= S_POLL;
			end
			S_READ: if (!pend) begin
				pend     <= 1'b1;
				cyc.req  <= 1'b1;
				cyc.wr   <= 1'b0;
				cyc.addr <= addr;
			end else if (cyc.done) begin
				pend  <= 1'b0;
				rdata <= cyc.rdata;
				if (op == fci_pkg::OP_RD_STAT)
					sr <= cyc.rdata;
				state <= S_DONE;
			end
			// each poll is a fresh cycle so the status latch refreshes
			S_POLL: if (!pend) begin
				pend     <= 1'b1;
				cyc.req  <= 1'b1;
				cyc.wr   <= 1'b0;
				cyc.addr <= addr;
			end else if (cyc.done) begin
				pend <= 1'b0;
				sr   <= cyc.rdata;
				if (cyc.rdata[fci_pkg::SR_READY])
					state <= S_DONE;
			end
			S_DONE: state <= S_IDLE;
			endcase
		end
	end

	// software registers
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			addr        <= 20'h00000;
			wdata       <= 8'h00;
			fl_rp_n_o   <= fci_pkg::CFG_RESET[fci_pkg::CFG_RP_N];
			fl_rp_hv_o  <= fci_pkg::CFG_RESET[fci_pkg::CFG_RP_HV];
			fl_vpp_en_o <= fci_pkg::CFG_RESET[fci_pkg::CFG_VPP_EN];
		end else if (wb_req & wb_we_i) begin
			case (wb_adr_i)
			fci_pkg::REG_ADDR: begin
				if (wb_sel_i[0])
					addr[7:0] <= wb_dat_i[7:0];
				if (wb_sel_i[1])
					addr[15:8] <= wb_dat_i[15:8];
				if (wb_sel_i[2])
					addr[19:16] <= wb_dat_i[19:16];
			end
			fci_pkg::REG_WDATA: if (wb_sel_i[0])
				wdata <= wb_dat_i[7:0];
			fci_pkg::REG_CFG: if (wb_sel_i[0]) begin
				fl_rp_n_o   <= wb_dat_i[fci_pkg::CFG_RP_N];
				fl_rp_hv_o  <= wb_dat_i[fci_pkg::CFG_RP_HV];
				fl_vpp_en_o <= wb_dat_i[fci_pkg::CFG_VPP_EN];
			end
			default: ;
			endcase
		end
	end

	// bus answer: one wait cycle, unmapped reads give zero
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= 32'h00000000;
			if (wb_req & ~wb_we_i) begin
				case (wb_adr_i)
				fci_pkg::REG_CTRL:  wb_dat_o <= {28'h0000000, op};
				fci_pkg::REG_ADDR:  wb_dat_o <= {12'h000, addr};
				fci_pkg::REG_WDATA: wb_dat_o <= {24'h000000, wdata};
				fci_pkg::REG_CFG:   wb_dat_o <= {29'h00000000,
					fl_vpp_en_o, fl_rp_hv_o, fl_rp_n_o};
				fci_pkg::REG_STATUS: begin
					wb_dat_o[fci_pkg::STS_BUSY]    <= (state != S_IDLE);
					wb_dat_o[fci_pkg::STS_REFUSED] <= refused;
					wb_dat_o[fci_pkg::STS_RDY_PIN] <= rdy_sync;
					wb_dat_o[fci_pkg::STS_SUSP]    <= sr[fci_pkg::SR_ESUSP];
					wb_dat_o[fci_pkg::STS_SR_LSB +: 8] <= sr;
					wb_dat_o[fci_pkg::STS_RD_LSB +: 8] <= rdata;
				end
				default: ;
				endcase
			end
		end
	end

	fci_pins u_pins (
		.clk_i   (clk_i),
		.rst_n_i (rst_n),
		.cyc     (cyc.slave),
		.dq_i    (fl_dq_i),
		.addr_o  (fl_addr_o),
		.dq_o    (fl_dq_o),
		.dq_oe_o (fl_dq_oe_o),
		.ce_n_o  (fl_ce_n_o),
		.oe_n_o  (fl_oe_n_o),
		.we_n_o  (fl_we_n_o)
	);
endmodule

// [tb/fci_flash_model.sv]
/* behavioural flash device on the controller pins: modes, status byte,
   erase, byte write, suspend and resume.
   assumes the pins change only on clk_i edges; clk_i is a time base. */
`timescale 1ns/1ps
module fci_flash_model #(
	parameter int         ER_CYC = 600,
	parameter int         WR_CYC = 30,
	parameter logic [7:0] MFR    = 8'h5a, // arbitrary value
	parameter logic [7:0] DEV    = 8'h3c  // arbitrary value
) (
	input  wire logic        clk_i,
	input  wire logic        ce_n_i,
	input  wire logic        oe_n_i,
	input  wire logic        we_n_i,
	input  wire logic [19:0] addr_i,
	input  wire logic [7:0]  dq_i,
	input  wire logic        dq_oe_i,
	input  wire logic        rp_n_i,
	input  wire logic        rp_hv_i,
	input  wire logic        vpp_i,
	output logic [7:0]       dq_o,
	output logic             ready_busy_n_o
);
	logic [7:0]  mem [int];
	logic [7:0]  sr   = 8'h80;
	logic [7:0]  lat  = 8'h80;
	logic [7:0]  last = 8'h00;
	logic [7:0]  pend = 8'h00;
	logic [7:0]  rd;
	logic [1:0]  mode = 2'd0;
	logic        pce  = 1'b1;
	logic        poe  = 1'b1;
	logic        pwe  = 1'b1;
	logic        sus  = 1'b0;
	logic        ers  = 1'b0;
	logic [19:0] ea   = 20'h0;
	int          bc   = 0;
	int          erem = 0;
	// block 1 is locked, the master lock is clear
	function automatic logic lk(logic [19:0] a);
		return a[19:16] == 4'h1;
	endfunction
	// read data of the current mode, no supply or reset gating
	always @* begin
		if (mode == 2'd2)
			rd = lat;
		else if (mode == 2'd1)
			rd = addr_i[1] ? {7'h0, addr_i[0] ? 1'b0 : lk(addr_i)}
				: addr_i[0] ? DEV : MFR;
		else
			rd = mem.exists(addr_i) ? mem[addr_i] : 8'hff;
	end
	// released bus shows a changing pattern, not the last value
	assign dq_o = dq_oe_i ? dq_i : (!ce_n_i && !oe_n_i) ? rd : ~last;
	assign ready_busy_n_o = sr[7] | !rp_n_i;
	// one captured command write
	task automatic cmd(logic [19:0] a, logic [7:0] d);
		if (pend == 8'h20) begin
			pend = 8'h00;
			mode = 2'd2;
			if (d != 8'hd0)
				sr |= 8'h30;
			else if (!vpp_i)
				sr |= 8'h28;
			else if (lk(a) && !rp_hv_i)
				sr |= 8'h22;
			else begin
				ea = a;
				erem = ER_CYC;
				ers = 1'b1;
				sr[7] = 1'b0;
			end
		end else if (pend != 8'h00) begin
			pend = 8'h00;
			mode = 2'd2;
			if (!vpp_i)
				sr |= 8'h18;
			else if (lk(a) && !rp_hv_i)
				sr |= 8'h12;
			else begin
				mem[a] = d;
				bc = WR_CYC;
				sr[7] = 1'b0;
			end
		end else if (d == 8'h70)
			mode = 2'd2;
		else if (!sr[7]) begin
			if (d == 8'hb0 && ers) begin
				sus = 1'b1;
				sr[7:6] = 2'b11;
			end
		end else if (sus) begin
			if (d == 8'hff)
				mode = 2'd0;
			else if (d == 8'h40 || d == 8'h10)
				pend = d;
			else if (d == 8'hd0) begin
				sus = 1'b0;
				sr[7:6] = 2'b00;
				mode = 2'd2;
			end
		end else if (d == 8'hff)
			mode = 2'd0;
		else if (d == 8'h90)
			mode = 2'd1;
		else if (d == 8'h50)
			sr[5:1] = 5'h0;
		else if (d == 8'h20 || d == 8'h40 || d == 8'h10)
			pend = d;
	endtask
	// pin edges, internal operation timing and power-down
	always @(posedge clk_i) begin
		if (!pwe && !pce && (we_n_i || ce_n_i))
			cmd(addr_i, dq_i);
		if (!ce_n_i && !oe_n_i && (pce || poe))
			lat = sr;
		if (bc > 0) begin
			bc--;
			if (bc == 0)
				sr[7] = 1'b1;
		end else if (ers && !sus && erem > 0) begin
			erem--;
			if (erem == 0) begin
				for (int i = 0; i < 65536; i++)
					mem.delete({ea[19:16], i[15:0]});
				ers = 1'b0;
				sr[7] = 1'b1;
			end
		end
		if (!rp_n_i)
			mode = 2'd0;
		last = dq_o;
		pce = ce_n_i;
		poe = oe_n_i;
		pwe = we_n_i;
	end
endmodule

// [tb/fci_top_assertions.sv]
/* pin and bus timing checks on the controller top ports.
   assumes one clock and the top reset as the disable. */
`timescale 1ns/1ps
module fci_top_assertions (
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        fl_dq_oe_o,
	input wire logic        fl_ce_n_o,
	input wire logic        fl_oe_n_o,
	input wire logic        fl_we_n_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	// bus answer, pulse and idle data
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o) else $error("request not answered");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	// write strobe shape
	a_we_width: assert property ($fell(fl_we_n_o)
		|=> !fl_we_n_o ##1 fl_we_n_o) else $error("strobe width");
	a_we_select: assert property ($rose(fl_we_n_o) |-> !fl_ce_n_o)
		else $error("strobe rose after select");
	a_we_drive: assert property (!fl_we_n_o
		|-> fl_dq_oe_o && fl_oe_n_o) else $error("write not driven");
	// read shape and toggling between cycles
	a_oe_width: assert property ($fell(fl_oe_n_o)
		|-> !fl_oe_n_o[*7] ##1 fl_oe_n_o) else $error("oe width");
	a_ce_gap: assert property ($rose(fl_ce_n_o) |-> fl_ce_n_o[*2])
		else $error("select gap too short");
	a_read_float: assert property (!fl_oe_n_o |-> !fl_dq_oe_o)
		else $error("data driven during read");
	c_write: cover property ($rose(fl_we_n_o));
	c_read: cover property ($rose(fl_oe_n_o));
	c_ack: cover property (wb_ack_o && wb_dat_o != 32'h0);
endmodule
bind fci_top fci_top_assertions u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .fl_dq_oe_o(fl_dq_oe_o), .fl_ce_n_o(fl_ce_n_o),
	.fl_oe_n_o(fl_oe_n_o), .fl_we_n_o(fl_we_n_o));

// [tb/fci_top_test.sv]
/* self-checking bench: wishbone master, flash model, expected memory.
   assumes the flash model file and the bound checker are compiled. */
`timescale 1ns/1ps
module fci_top_test;
	localparam logic [7:0] MFR = 8'h5a; // arbitrary value
	localparam logic [7:0] DEV = 8'h3c; // arbitrary value
	logic        clk_i = 0, rst_n_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
	logic        wb_we_i = 0, wb_ack_o, fl_dq_oe_o, fl_ce_n_o, fl_oe_n_o;
	logic        fl_we_n_o, fl_rp_n_o, fl_rp_hv_o, fl_vpp_en_o;
	logic        fl_ready_busy_n_i;
	logic [7:0]  wb_adr_i = 0, fl_dq_i, fl_dq_o, d;
	logic [31:0] wb_dat_i = 0, wb_dat_o, r;
	logic [3:0]  wb_sel_i = 0;
	logic [19:0] fl_addr_o, a;
	logic [7:0]  em [int];
	logic [19:0] ia [5] = '{20'h0, 20'h1, 20'h2, 20'h3, 20'h10002};
	logic [7:0]  iv [5] = '{MFR, DEV, 8'h0, 8'h0, 8'h1};
	logic [2:0]  fc [4] = '{3'h1, 3'h1, 3'h5, 3'h5};
	logic [7:0]  fs [4] = '{8'ha8, 8'h98, 8'ha2, 8'h92};
	int          fails = 0, tests_run = 0, i, n;
	always #12.5 clk_i = ~clk_i;
	fci_top DUT (.*);
	fci_flash_model #(.MFR(MFR), .DEV(DEV)) u_flash (.clk_i(clk_i),
		.ce_n_i(fl_ce_n_o), .oe_n_i(fl_oe_n_o), .we_n_i(fl_we_n_o),
		.addr_i(fl_addr_o), .dq_i(fl_dq_o), .dq_oe_i(fl_dq_oe_o),
		.rp_n_i(fl_rp_n_o), .rp_hv_i(fl_rp_hv_o), .vpp_i(fl_vpp_en_o),
		.dq_o(fl_dq_i), .ready_busy_n_o(fl_ready_busy_n_i));
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one classic cycle, held until ack is sampled
	task automatic wb(logic w, logic [7:0] ad, logic [31:0] dt);
		int k;
		k = 0;
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= w;
		wb_adr_i <= ad;
		wb_dat_i <= dt;
		wb_sel_i <= 4'hf;
		// ack is only looked at on edges after the request was raised
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 8);
		if (wb_ack_o !== 1'b1) begin
			fails++;
			print_verdict;
		end
		r = wb_dat_o;
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
		@(posedge clk_i);
	endtask
	task automatic st;
		wb(0, fci_pkg::REG_STATUS, 0);
	endtask
	// start an operation and wait until it is no longer busy
	task automatic op(logic [3:0] o, logic [19:0] ad, logic [7:0] dt);
		int k;
		wb(1, fci_pkg::REG_ADDR, {12'h0, ad});
		wb(1, fci_pkg::REG_WDATA, {24'h0, dt});
		wb(1, fci_pkg::REG_CTRL, {28'h0, o});
		for (k = 0; k < 3000; k++) begin
			st;
			if (r[fci_pkg::STS_BUSY] === 1'b0)
				break;
		end
		if (k == 3000) begin
			fails++;
			print_verdict;
		end
	endtask
	task automatic tend(string nm);
		$display("test %s ended", nm);
	endtask
	// main sequence
	initial begin
		void'($urandom(77922));
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1;
		repeat (3) @(posedge clk_i);
		chk("pins", 4'hb, {fl_vpp_en_o, fl_rp_hv_o, fl_rp_n_o, fl_ce_n_o});
		wb(0, fci_pkg::REG_CFG, 0);
		chk("cfg", 32'h5, r);
		wb(0, 8'h14, 0);
		chk("unmapped", 0, r);
		st;
		chk("sr reset", 8'h80, r[15:8]);
		a = {4'h0, 16'($urandom)};
		op(fci_pkg::OP_READ, a, 0);
		chk("power-up", 8'hff, r[23:16]);
		tend("reset");
		op(fci_pkg::OP_RD_ID, 0, 0);
		for (i = 0; i < 5; i++) begin
			op(fci_pkg::OP_READ, ia[i], 0);
			chk("id", iv[i], r[23:16]);
		end
		tend("ident");
		d = 8'($urandom);
		op(fci_pkg::OP_BYTE_WR, a, d);
		em[a] = d;
		st;
		chk("sr write", 8'h80, r[15:8]);
		op(fci_pkg::OP_RD_ARRAY, a, 0);
		chk("array", em[a], r[23:16]);
		op(fci_pkg::OP_ERASE, a, 0);
		op(fci_pkg::OP_RD_ARRAY, a, 0);
		chk("erased", 8'hff, r[23:16]);
		tend("write erase");
		for (i = 0; i < 4; i++) begin
			wb(1, fci_pkg::REG_CFG, fc[i]);
			op(i[0] ? fci_pkg::OP_BYTE_WR : fci_pkg::OP_ERASE,
				{3'h0, i[1], 16'h40}, 0);
			chk("fault", fs[i], r[15:8]);
			op(fci_pkg::OP_RD_STAT, 0, 0);
			chk("sticky", fs[i], r[23:16]);
			op(fci_pkg::OP_CLR_STAT, 0, 0);
			op(fci_pkg::OP_RD_STAT, 0, 0);
			chk("cleared", 8'h80, r[23:16]);
		end
		wb(1, fci_pkg::REG_CFG, 3'h7);
		a = {4'h1, 16'($urandom)};
		op(fci_pkg::OP_BYTE_WR, a, d);
		em[a] = d;
		op(fci_pkg::OP_RD_ARRAY, a, 0);
		chk("override", em[a], r[23:16]);
		wb(1, fci_pkg::REG_CFG, 3'h5);
		op(fci_pkg::OP_RAW_WR, 20'h20000, fci_pkg::CMD_ERASE);
		op(fci_pkg::OP_RAW_WR, 20'h20000, 8'h00);
		op(fci_pkg::OP_RD_STAT, 0, 0);
		chk("bad confirm", 8'hb0, r[23:16]);
		op(fci_pkg::OP_CLR_STAT, 0, 0);
		tend("faults");
		op(fci_pkg::OP_RAW_WR, 20'h30000, fci_pkg::CMD_ERASE);
		op(fci_pkg::OP_RAW_WR, 20'h30000, fci_pkg::CMD_CONFIRM);
		op(fci_pkg::OP_RAW_WR, 0, fci_pkg::CMD_RD_ARRAY);
		op(fci_pkg::OP_READ, 20'h30000, 0);
		chk("ff ignored", 8'h00, r[23:16]);
		op(fci_pkg::OP_SUSPEND, 0, 0);
		chk("suspended", 8'hc0, r[15:8]);
		chk("susp pins", 2'h3, r[3:2]);
		op(fci_pkg::OP_CLR_STAT, 0, 0);
		chk("clear refused", 1, r[fci_pkg::STS_REFUSED]);
		d = 8'($urandom);
		op(fci_pkg::OP_BYTE_WR, 20'h10, d);
		em[20'h10] = d;
		chk("susp write", 8'hc0, r[15:8]);
		op(fci_pkg::OP_RESUME, 0, 0);
		op(fci_pkg::OP_RD_STAT, 0, 0);
		chk("resumed", 8'h00, r[23:16]);
		chk("busy pin", 0, r[fci_pkg::STS_RDY_PIN]);
		for (n = 0; n < 200 && r[23] !== 1'b1; n++)
			op(fci_pkg::OP_RD_STAT, 0, 0);
		chk("erase done", 8'h80, r[23:16]);
		op(fci_pkg::OP_RD_ARRAY, 20'h10, 0);
		chk("susp data", em[20'h10], r[23:16]);
		tend("suspend");
		op(fci_pkg::OP_RD_ID, 0, 0);
		wb(1, fci_pkg::REG_CFG, 3'h4);
		chk("rp pin", 0, fl_rp_n_o);
		wb(1, fci_pkg::REG_CFG, 3'h5);
		op(fci_pkg::OP_READ, 20'h10, 0);
		chk("pd exit", em[20'h10], r[23:16]);
		tend("power-down");
		print_verdict;
	end
endmodule
